/* File: common/cache_pkg.sv */
// shared constants for the prefetch cache control block
package cache_pkg;
  // ==========================================================
  // register offsets (byte addresses, chosen)
  localparam logic [3:0] CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] MASK_OFFSET    = 4'h4;
  localparam logic [3:0] ACCESS_OFFSET  = 4'h8;
  localparam logic [3:0] WORD0_OFFSET   = 4'hc;
  // ==========================================================
  // cache_control fields
  localparam int COHERENCY_BIT = 16;
  localparam int DCOUNT_LSB    = 8;
  localparam int PREFETCH_LSB  = 4;
  localparam int WAIT_LSB      = 0;
  localparam logic [2:0] WAIT_RESET = 3'h7;
  // ==========================================================
  // cache_tag_mask field
  localparam int MASK_LSB   = 5;
  localparam int MASK_WIDTH = 11;
  // line indices whose mask may be written
  localparam logic [3:0] MASK_LINE_A = 4'ha;
  localparam logic [3:0] MASK_LINE_B = 4'hb;
  // ==========================================================
  // cache geometry and encodings
  localparam int LINES      = 16;
  localparam int IDX_WIDTH  = 4;
  localparam int TAG_WIDTH  = 20;
  localparam logic [1:0] DCOUNT_OFF  = 2'h0;
  localparam logic [1:0] DCOUNT_ONE  = 2'h1;
  localparam logic [1:0] DCOUNT_TWO  = 2'h2;
  localparam logic [1:0] DCOUNT_FOUR = 2'h3;
  localparam logic [1:0] PREF_OFF    = 2'h0;
  localparam logic [1:0] PREF_CACHED = 2'h1;
  localparam logic [1:0] PREF_UNCACH = 2'h2;
  localparam logic [1:0] PREF_BOTH   = 2'h3;
endpackage

/* File: src/line_word_mem.sv */
// word-0 storage for every cache line, registered read
`timescale 1ns/1ps
module line_word_mem (
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  waddr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  raddr_i,
  output logic      [31:0] rdata_o
);
  logic [31:0] mem [cache_pkg::LINES];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // line_word_mem

/* File: src/prefetch_cache_control.sv */
// prefetch cache control registers, line valid state and flash timing
`timescale 1ns/1ps
// Summary of operation
// R1: a flash program cycle invalidates all lines when coherency is 1, otherwise all but locked instruction lines.
// R2: the data line count field 11/10/01/00 allows four, two, one or no data lines.
// R3: any write that changes the data line count invalidates every line, bar locked instruction lines kept by a same-cycle program cycle.
// R4: prefetch field 11 enables both regions, 10 non-cacheable only, 01 cacheable only, 00 none.
// R5: the wait-state field gives program flash wait states in system clocks, zero to seven.
// R6: a set mask bit forces a match on that tag bit, a clear one compares normally.
// R7: the mask field is written only while the line index selects line 0x0a or 0x0b.
// R8: software writes unimplemented bits as zero and ignores their read value.
// R9: word zero of the indexed line is readable only when the device is not code protected.
module prefetch_cache_control (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        code_protect_i,
  input  wire logic        flash_program_i,
  input  wire logic [19:0] fetch_tag_i,
  input  wire logic        flash_start_i,
  input  wire logic        region_cacheable_i,
  output logic      [15:0] line_valid_o,
  output logic      [15:0] line_hit_o,
  output logic             flash_ready_o,
  output logic             prefetch_allow_o,
  output logic      [2:0]  data_line_limit_o
);
  // ==========================================================
  // state
  typedef enum logic [1:0] {
    FL_IDLE = 2'b01,
    FL_WAIT = 2'b10
  } flash_state_t;

  typedef struct packed {
    // bus answer and control fields
    logic                 ack;
    logic                 coherency_invalidate_all;
    logic [1:0]           data_cache_line_count;
    logic [1:0]           predictive_prefetch_enable;
    logic [2:0]           flash_wait_states;
    // line selection and per-line state
    logic [3:0]           line_index;
    logic [15:0]          valid;
    logic [15:0]          locked;
    logic [15:0]          is_instr;
    logic [10:0]          mask_a;
    logic [10:0]          mask_b;
    // read data held for the acknowledge cycle
    logic [31:0]          rdata;
    logic                 rd_word0;
    // flash access timing
    flash_state_t         fstate;
    logic [2:0]           wcount;
    logic                 fready;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // reset image of the whole state; the wait field starts at its slowest setting
  localparam state_t RESET_STATE = '{
    ack:                        1'b0,
    coherency_invalidate_all:   1'b0,
    data_cache_line_count:      2'h0,
    predictive_prefetch_enable: 2'h0,
    flash_wait_states:          cache_pkg::WAIT_RESET,
    line_index:                 4'h0,
    valid:                      16'h0,
    locked:                     16'h0,
    is_instr:                   16'h0,
    mask_a:                     11'h0,
    mask_b:                     11'h0,
    rdata:                      32'h0,
    rd_word0:                   1'b0,
    fstate:                     FL_IDLE,
    wcount:                     3'h0,
    fready:                     1'b0
  };

  logic [19:0] line_tag [cache_pkg::LINES];
  logic        mem_we;
  logic [31:0] mem_rdata;
  logic        req;
  logic        wr;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] cur;
  logic [15:0] keep_lines;

  // ==========================================================
  // bus decode
  // ack is registered, so the edge that sees it high must not take the request again
  assign req = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign wr  = req && wb_we_i;
  assign mem_we = wr && (wb_adr_i == cache_pkg::WORD0_OFFSET);

  // word 0 is read every cycle from the indexed line, so read data stand with ack
  line_word_mem line_word_mem_i (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (st_reg.line_index),
    .wdata_i (wb_dat_i),
    .raddr_i (st_reg.line_index),
    .rdata_o (mem_rdata)
  );

  // ==========================================================
  // tag storage: tags load from the fetch path when a line is written through word 0
  // tags need no reset: a line is compared only once its valid bit is set
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      line_tag[st_reg.line_index] <= fetch_tag_i;
    end
  end

  // ==========================================================
  // tag compare, one comparator per line
  genvar g;
  generate
    for (g = 0; g < cache_pkg::LINES; g++) begin : g_cmp
      logic [19:0] force_bits;
      always_comb begin
        force_bits = 20'h0;
        // mask positions sit over tag bits 19:9
        // only lines 0x0a and 0x0b carry a mask; the rest compare every tag bit
        if (g == int'(cache_pkg::MASK_LINE_A)) begin
          force_bits[19:9] = st_reg.mask_a; // R6
        end else if (g == int'(cache_pkg::MASK_LINE_B)) begin
          force_bits[19:9] = st_reg.mask_b; // R6
        end
      end
      assign line_hit_o[g] = st_reg.valid[g] &&
                             (((line_tag[g] ^ fetch_tag_i) & ~force_bits) == 20'h0); // R6
    end
  endgenerate

  // ==========================================================
  // byte-lane merge
  // unselected bytes take their read value, so a one-byte write leaves the other fields; word 0 writes take all four bytes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // ==========================================================
  // read view of the registers
  // unimplemented bits read as zero; word 0 comes through the memory path instead
  always_comb begin
    cur = 32'h0;
    unique case (wb_adr_i)
      cache_pkg::CONTROL_OFFSET: begin
        cur[cache_pkg::COHERENCY_BIT]            = st_reg.coherency_invalidate_all;
        cur[cache_pkg::DCOUNT_LSB +: 2]          = st_reg.data_cache_line_count;
        cur[cache_pkg::PREFETCH_LSB +: 2]        = st_reg.predictive_prefetch_enable;
        cur[cache_pkg::WAIT_LSB +: 3]            = st_reg.flash_wait_states;
      end
      cache_pkg::MASK_OFFSET: begin
        if (st_reg.line_index == cache_pkg::MASK_LINE_B) begin
          cur[cache_pkg::MASK_LSB +: cache_pkg::MASK_WIDTH] = st_reg.mask_b;
        end else if (st_reg.line_index == cache_pkg::MASK_LINE_A) begin
          cur[cache_pkg::MASK_LSB +: cache_pkg::MASK_WIDTH] = st_reg.mask_a;
        end
      end
      cache_pkg::ACCESS_OFFSET: begin
        cur[3:0] = st_reg.line_index;
      end
      default: begin
        cur = 32'h0;
      end
    endcase
    wval = (wb_dat_i & wmask) | (cur & ~wmask);
  end

  // ==========================================================
  // lines kept across a flash program cycle
  // with coherency clear, locked instruction lines stay so pinned code keeps running;
  // data lines always go, as they may hold words that the program cycle changed
  always_comb begin
    if (st_reg.coherency_invalidate_all) begin
      keep_lines = 16'h0; // R1
    end else begin
      keep_lines = st_reg.locked & st_reg.is_instr; // R1
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    // ==========================================================
    // register reads and writes
    st_next.ack = req;
    st_next.rd_word0 = 1'b0;
    if (req && !wb_we_i) begin
      st_next.rdata = cur; // R8
      // protection is sampled with the request, so one read sees one decision
      st_next.rd_word0 = (wb_adr_i == cache_pkg::WORD0_OFFSET) && !code_protect_i; // R9
    end
    if (wr) begin
      unique case (wb_adr_i)
        cache_pkg::CONTROL_OFFSET: begin
          st_next.coherency_invalidate_all   = wval[cache_pkg::COHERENCY_BIT];
          st_next.data_cache_line_count      = wval[cache_pkg::DCOUNT_LSB +: 2];
          st_next.predictive_prefetch_enable = wval[cache_pkg::PREFETCH_LSB +: 2];
          st_next.flash_wait_states          = wval[cache_pkg::WAIT_LSB +: 3];
          if (wval[cache_pkg::DCOUNT_LSB +: 2] != st_reg.data_cache_line_count) begin
            st_next.valid = 16'h0; // R3
          end
        end
        cache_pkg::MASK_OFFSET: begin
          if (st_reg.line_index == cache_pkg::MASK_LINE_A) begin
            st_next.mask_a = wval[cache_pkg::MASK_LSB +: cache_pkg::MASK_WIDTH]; // R7
          end else if (st_reg.line_index == cache_pkg::MASK_LINE_B) begin
            st_next.mask_b = wval[cache_pkg::MASK_LSB +: cache_pkg::MASK_WIDTH]; // R7
          end
        end
        cache_pkg::ACCESS_OFFSET: begin
          st_next.line_index = wval[3:0];
          // bit 4 marks a locked line, bit 5 an instruction line
          // lock and instruction bits are write-only; reads show the index alone
          st_next.locked[wval[3:0]]   = wval[4];
          st_next.is_instr[wval[3:0]] = wval[5];
        end
        cache_pkg::WORD0_OFFSET: begin
          // the fill marks the line valid; its tag is captured in the same cycle
          st_next.valid[st_reg.line_index] = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // ==========================================================
    // line invalidation
    // a flash program cycle wins over a same-cycle line fill or size change
    if (flash_program_i) begin
      st_next.valid = st_reg.valid & keep_lines; // R1
    end
    // ==========================================================
    // flash access timing
    // starts that arrive while a wait runs are dropped; the fetch path holds off until ready
    st_next.fready = 1'b0;
    unique case (st_reg.fstate)
      FL_IDLE: begin
        // with zero wait states the answer comes on the next cycle
        if (flash_start_i) begin
          if (st_reg.flash_wait_states == 3'h0) begin
            st_next.fready = 1'b1; // R5
          end else begin
            st_next.wcount = st_reg.flash_wait_states; // R5
            st_next.fstate = FL_WAIT;
          end
        end
      end
      // the count runs down from the field value taken at the start
      FL_WAIT: begin
        st_next.wcount = st_reg.wcount - 3'h1;
        if (st_reg.wcount == 3'h1) begin
          st_next.fready = 1'b1; // R5
          st_next.fstate = FL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= RESET_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  // protected parts read word 0 as zero so code cannot be dumped
  assign wb_dat_o = st_reg.rd_word0 ? mem_rdata : st_reg.rdata; // R9
  assign wb_ack_o = st_reg.ack;
  assign line_valid_o = st_reg.valid;
  assign flash_ready_o = st_reg.fready;

  // ==========================================================
  // prefetch enable and data line limit
  always_comb begin
    unique case (st_reg.predictive_prefetch_enable)
      cache_pkg::PREF_OFF:    prefetch_allow_o = 1'b0; // R4
      cache_pkg::PREF_CACHED: prefetch_allow_o = region_cacheable_i; // R4
      cache_pkg::PREF_UNCACH: prefetch_allow_o = !region_cacheable_i; // R4
      cache_pkg::PREF_BOTH:   prefetch_allow_o = 1'b1; // R4
    endcase
  end

  // the limit feeds the line allocator; zero means no line may take data
  always_comb begin
    unique case (st_reg.data_cache_line_count)
      cache_pkg::DCOUNT_OFF:  data_line_limit_o = 3'h0; // R2
      cache_pkg::DCOUNT_ONE:  data_line_limit_o = 3'h1; // R2
      cache_pkg::DCOUNT_TWO:  data_line_limit_o = 3'h2; // R2
      cache_pkg::DCOUNT_FOUR: data_line_limit_o = 3'h4; // R2
    endcase
  end
endmodule // prefetch_cache_control

/* File: test/flash_fetch_model.sv */
// fetch path model that starts flash accesses and times the answer
`timescale 1ns/1ps
module flash_fetch_model (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic ready_i,
  output logic      start_o,
  output int        lat_o
);
  logic start_q = 1'b0;
  int   lat_q   = 0;
  int   n       = 0;
  assign start_o = start_q;
  assign lat_o   = lat_q;
  // lat_o holds edges from the start to the answer, stale until one arrives
  always @(posedge clk_i) begin
    start_q <= go_i;
    if (ready_i && n != 0) begin
      lat_q <= n;
      n <= 0;
    end else if (start_q) n <= 1;
    else if (n != 0) n <= n + 1;
  end
endmodule // flash_fetch_model

/* File: test/prefetch_cache_control_properties.sv */
// assertion checker bound to the prefetch cache control block
`timescale 1ns/1ps
module prefetch_cache_control_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic        code_protect_i,
  input wire logic        flash_program_i,
  input wire logic        flash_start_i,
  input wire logic        region_cacheable_i,
  input wire logic [15:0] line_valid_o,
  input wire logic        flash_ready_o,
  input wire logic        prefetch_allow_o,
  input wire logic [2:0]  data_line_limit_o
);
  // ==========
  // shadow of the control fields, taken at the acknowledging edge
  logic [2:0] ws_q;
  logic [1:0] dc_q, pf_q;
  logic       coh_q, wr;
  logic [3:0] cnt_q;
  assign wr = wb_ack_o && wb_we_i && wb_adr_i == cache_pkg::CONTROL_OFFSET;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ws_q <= cache_pkg::WAIT_RESET;
      dc_q <= 2'h0;
      pf_q <= 2'h0;
      coh_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      if (wr && wb_sel_i[0]) ws_q <= wb_dat_i[2:0];
      if (wr && wb_sel_i[0]) pf_q <= wb_dat_i[5:4];
      if (wr && wb_sel_i[1]) dc_q <= wb_dat_i[9:8];
      if (wr && wb_sel_i[2]) coh_q <= wb_dat_i[16];
      // a start is taken when idle or on the answer edge, dropped while a wait runs
      if (flash_start_i && cnt_q <= 4'h1) cnt_q <= {1'b0, ws_q} + 4'h1;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_coh_all: assert property (flash_program_i && coh_q |=> line_valid_o == 16'h0)
    else $error("lines kept after full invalidate");
  chk_coh_keep: assert property (flash_program_i && !coh_q |=> (line_valid_o & ~$past(line_valid_o)) == 16'h0)
    else $error("line became valid on program cycle");
  chk_limit_map: assert property (!wb_ack_o |-> data_line_limit_o == (dc_q == 2'h3 ? 3'h4 : {1'b0, dc_q}))
    else $error("data line limit wrong");
  chk_size_inval: assert property (wr && wb_sel_i[1] && wb_dat_i[9:8] != dc_q |=> line_valid_o == 16'h0)
    else $error("size change left lines valid");
  chk_pref_map: assert property (!wb_ack_o |-> prefetch_allow_o == (region_cacheable_i ? pf_q[0] : pf_q[1]))
    else $error("prefetch enable wrong");
  chk_wait_end: assert property (cnt_q == 4'h1 |-> flash_ready_o)
    else $error("flash ready late");
  chk_ready_cause: assert property (flash_ready_o |-> cnt_q == 4'h1)
    else $error("flash ready early or spurious");
  chk_prot_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == cache_pkg::WORD0_OFFSET
    && code_protect_i |-> wb_dat_o == 32'h0)
    else $error("protected word read leaked");
  cover property (flash_program_i && !coh_q);
  cover property (cnt_q == 4'h8);
  cover property (wb_ack_o && code_protect_i && !wb_we_i);
endmodule // prefetch_cache_control_properties
bind prefetch_cache_control prefetch_cache_control_properties prefetch_cache_control_properties_i (.clk_i, .rst_i,
  .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i, .wb_ack_o, .code_protect_i, .flash_program_i,
  .flash_start_i, .region_cacheable_i, .line_valid_o, .flash_ready_o, .prefetch_allow_o, .data_line_limit_o);

/* File: test/prefetch_cache_control_tb.sv */
// register-level bench for the prefetch cache control block
`timescale 1ns/1ps
module prefetch_cache_control_tb;
  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, code_protect_i, flash_program_i;
  logic        flash_start_i, region_cacheable_i, flash_ready_o, prefetch_allow_o, go;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [19:0] fetch_tag_i;
  logic [15:0] line_valid_o, line_hit_o;
  logic [2:0]  data_line_limit_o;
  int          lat, miscompares, cmp_count, cycles;
  localparam logic [3:0] CTL = cache_pkg::CONTROL_OFFSET;
  localparam logic [3:0] MSK = cache_pkg::MASK_OFFSET;
  localparam logic [3:0] ACC = cache_pkg::ACCESS_OFFSET;
  localparam logic [3:0] WD0 = cache_pkg::WORD0_OFFSET;
  prefetch_cache_control prefetch_cache_control_i (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .code_protect_i, .flash_program_i, .fetch_tag_i, .flash_start_i,
    .region_cacheable_i, .line_valid_o, .line_hit_o, .flash_ready_o, .prefetch_allow_o, .data_line_limit_o);
  flash_fetch_model flash_fetch_model_i (.clk_i(clk_i), .go_i(go), .ready_i(flash_ready_o),
    .start_o(flash_start_i), .lat_o(lat));
  // ==========
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse_program();
    flash_program_i <= 1'b1;
    @(posedge clk_i);
    flash_program_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // clock, timeout and tests
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, code_protect_i, flash_program_i, region_cacheable_i, go} = 8'h80;
    {wb_adr_i, wb_sel_i, wb_dat_i, fetch_tag_i} = {4'h0, 4'hf, 32'h0, 20'h12345};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, CTL, 32'h0);
    check(rd, 32'h7);
    for (int i = 0; i < 4; i++) begin
      bus(1, CTL, 32'(i * 32'h111));
      bus(0, CTL, 32'h0);
      check(rd, 32'(i * 32'h111));
      check(32'(data_line_limit_o), (i == 3) ? 32'h4 : 32'(i));
      region_cacheable_i <= 1'b1;
      @(posedge clk_i);
      check(32'(prefetch_allow_o), 32'(i % 2));
      region_cacheable_i <= 1'b0;
      @(posedge clk_i);
      check(32'(prefetch_allow_o), 32'(i / 2));
    end
    for (int w = 0; w < 8; w++) begin
      bus(1, CTL, 32'(w));
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (w + 4) @(posedge clk_i);
      check(32'(lat), 32'(w + 1));
    end
    wb_sel_i <= 4'h2;
    bus(1, CTL, 32'h00010330);
    wb_sel_i <= 4'hf;
    bus(0, CTL, 32'h0);
    check(rd, 32'h307);
    bus(1, CTL, 32'h00010300);
    bus(1, ACC, 32'h5);
    bus(1, WD0, 32'hcafe0005);
    check(32'(line_hit_o), 32'h20);
    bus(0, WD0, 32'h0);
    check(rd, 32'hcafe0005);
    code_protect_i <= 1'b1;
    bus(0, WD0, 32'h0);
    check(rd, 32'h0);
    code_protect_i <= 1'b0;
    pulse_program();
    check(32'(line_valid_o), 32'h0);
    bus(1, CTL, 32'h00000300);
    bus(1, ACC, 32'h35);
    bus(1, WD0, 32'h5);
    bus(1, ACC, 32'h6);
    bus(1, WD0, 32'h6);
    pulse_program();
    check(32'(line_valid_o), 32'h20);
    bus(1, CTL, 32'h00000300);
    check(32'(line_valid_o), 32'h20);
    bus(1, CTL, 32'h00000200);
    check(32'(line_valid_o), 32'h0);
    bus(1, ACC, 32'ha);
    bus(1, WD0, 32'ha);
    bus(1, MSK, 32'hffe0);
    bus(0, MSK, 32'h0);
    check(rd, 32'hffe0);
    fetch_tag_i <= 20'h12345 ^ 20'hffe00;
    @(posedge clk_i);
    check(32'(line_hit_o), 32'h400);
    fetch_tag_i <= 20'h12345 ^ 20'h00100;
    @(posedge clk_i);
    check(32'(line_hit_o), 32'h0);
    bus(1, ACC, 32'h3);
    bus(1, MSK, 32'h0);
    bus(0, MSK, 32'h0);
    check(rd, 32'h0);
    bus(1, ACC, 32'ha);
    bus(0, MSK, 32'h0);
    check(rd, 32'hffe0);
    bus(1, ACC, 32'hb);
    bus(1, MSK, 32'h8020);
    bus(0, MSK, 32'h0);
    check(rd, 32'h8020);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, CTL, 32'h0);
    check(rd, 32'h7);
    check(32'(line_valid_o), 32'h0);
    summarize();
  end
endmodule // prefetch_cache_control_tb
